// >>> design/bridge_aw_pkg.sv
// Package of shared types and constants for the master-side write-address front end
// Contract
// [R1] In independent-clock mode the slave port is sampled and driven only on the slave-port clock.
// [R2] In common-clock mode every master-side operation, link side included, runs from the slave-port clock.
// [R3] The physical-link clock is used only in independent-clock mode, where all but the slave port follows it; the code paces only the beat engine by it.
// [R4] With the serial-transceiver link, the transceiver supplies the physical-link clock.
// [R5] With the deskewed parallel link, outside logic supplies a 200 MHz or 300 MHz (+/-10 MHz) delay reference clock.
// [R6] The global reset is active low and is sampled synchronously to the clock; the code clears its registers asynchronously while reset_n is low.
// [R7] The system keeps every used clock stable before releasing the global reset.
// [R8] In lightweight slave mode the lightweight master port is sampled on rising edges of its own clock.
// [R9] In lightweight master mode the lightweight slave port is sampled on rising edges of its own clock.
// [R10] The identifier width is a parameter from 1 to 6 bits and tags each write address group.
// [R11] The 32-bit write address holds the first beat only; later beat addresses come from burst control.
// [R12] The 8-bit burst length gives the exact number of beats tied to the address.
// [R13] The 2-bit burst size gives the byte size of each beat; strobes pick the lanes.
// [R14] Each beat address is computed from the burst type together with the burst size.
// [R15] The upstream master holds address and control stable while valid is high until ready rises.
// [R16] A write address transfer completes on an edge with valid and ready high; all fields are captured there.
package bridge_aw_pkg;

  localparam int unsigned ID_WIDTH_MAX       = 6;
  localparam int unsigned FIFO_DEPTH_DEFAULT = 32;
  localparam int unsigned LITE_WIDTH         = 32;

  // Burst type encodings
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_INCR  = 2'h1;
  localparam logic [1:0] BURST_WRAP  = 2'h2;

  // Bit positions of the pins passed through the input synchronisers
  localparam int unsigned PIN_RESET  = 0;
  localparam int unsigned PIN_PHY    = 1;
  localparam int unsigned PIN_LITE_M = 2;
  localparam int unsigned PIN_LITE_S = 3;
  localparam int unsigned PIN_COUNT  = 4;

  // Reset values
  localparam logic [PIN_COUNT-1:0] PIN_LEVEL_RESET = 4'h0;

  // One accepted write address group
  typedef struct packed {
    logic [ID_WIDTH_MAX-1:0] id;
    logic [31:0]             addr;
    logic [7:0]              len;
    logic [1:0]              size;
    logic [1:0]              burst;
  } aw_req_t;

  // One beat handed to the link side
  typedef struct packed {
    logic [ID_WIDTH_MAX-1:0] id;
    logic [31:0]             addr;
    logic [1:0]              size;
    logic                    last;
  } aw_beat_t;

endpackage

// >>> design/aw_fifo.sv
// Synchronous FIFO with registered read data, used to queue write address groups
`timescale 1ns/100ps
`default_nettype none

module aw_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             flush,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad_geometry
    $error("aw_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_t;

  fifo_state_t      q;
  fifo_state_t      d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             load;

  // Full is honest: the count covers only words held in the array
  assign in_ready  = (q.count != CW'(DEPTH));
  assign out_valid = q.out_valid;
  assign out_data  = q.out_data;

  // Pointer, count and output stage update
  always_comb
  begin
    d    = q;
    push = in_valid & in_ready;
    load = (q.count != '0) & (~q.out_valid | out_ready);
    if (out_ready & q.out_valid)
    begin
      d.out_valid = 1'b0;
    end
    if (load)
    begin
      d.out_valid = 1'b1;
      d.out_data  = mem[q.rd_ptr];
      d.rd_ptr    = q.rd_ptr + PW'(1);
    end
    if (push)
    begin
      d.wr_ptr = q.wr_ptr + PW'(1);
    end
    d.count = q.count + CW'(push) - CW'(load);
    if (flush)
    begin
      d = '0;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Array write kept out of the reset path so it maps onto RAM
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[q.wr_ptr] <= in_data;
    end
  end

endmodule

`default_nettype wire

// >>> design/bridge_aw_front.sv
// Clocking, reset and write-address front end of the bridge master side
`timescale 1ns/100ps
`default_nettype none

module bridge_aw_front
  import bridge_aw_pkg::*;
#(
  parameter bit          COMMON_CLOCK_MODE  = 1'b1,
  parameter bit          LITE_SLAVE_MODE    = 1'b1,
  parameter int unsigned id_width_parameter = ID_WIDTH_MAX,
  parameter int unsigned FIFO_DEPTH         = FIFO_DEPTH_DEFAULT
) (
  // Slave-port clock and global reset
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  // Clocks sampled as plain inputs
  input  wire logic                          physical_link_clock,
  input  wire logic                          lite_master_clock,
  input  wire logic                          lite_slave_clock,
  // Write address channel
  input  wire logic [id_width_parameter-1:0] s_axi_awid,
  input  wire logic [31:0]                   s_axi_awaddr,
  input  wire logic [7:0]                    s_axi_awlen,
  input  wire logic [1:0]                    s_axi_awsize,
  input  wire logic [1:0]                    s_axi_awburst,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // Beat addresses toward the link side
  output logic                               beat_valid,
  output aw_beat_t                           beat,
  input  wire logic                          beat_ready,
  // Lightweight port word capture
  input  wire logic                          lite_in_valid,
  input  wire logic [LITE_WIDTH-1:0]         lite_in_data,
  output logic                               lite_word_valid,
  output logic [LITE_WIDTH-1:0]              lite_word
);

  if (id_width_parameter < 1 || id_width_parameter > ID_WIDTH_MAX)
  begin : g_bad_id_width
    $error("bridge_aw_front: identifier width must be 1 to 6");   // R10
  end

  typedef struct packed {
    logic [PIN_COUNT-1:0]             s1;
    logic [PIN_COUNT-1:0]             s2;
    logic [PIN_COUNT-1:0]             s3;
    logic [PIN_COUNT-1:0]             lvl;
    logic [2:0][LITE_WIDTH:0]         lite_pipe;
    logic                             lite_valid;
    logic [LITE_WIDTH-1:0]            lite_word;
    logic                             awready;
    logic                             hold_valid;
    aw_req_t                          hold;
    logic                             busy;
    aw_req_t                          cur;
    logic [7:0]                       left;
    logic                             beat_valid;
    aw_beat_t                         beat;
  } front_state_t;

  front_state_t         q;
  front_state_t         d;
  logic [PIN_COUNT-1:0] agree;
  logic [PIN_COUNT-1:0] rise;
  logic                 in_rst;
  logic                 link_step;
  logic                 lite_edge;
  logic                 fire;
  logic                 adv;
  logic                 pop;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [$bits(aw_req_t)-1:0] fifo_out_raw;
  aw_req_t              fifo_head;

  assign fifo_head = aw_req_t'(fifo_out_raw);

  // Address of the following beat from burst type, size and length
  function automatic logic [31:0] next_addr(input aw_req_t r);
    logic [31:0] inc;
    logic [31:0] mask;
    inc  = 32'h1 << r.size;
    mask = (({24'h0, r.len} + 32'h1) << r.size) - 32'h1;
    case (r.burst)
      BURST_FIXED: next_addr = r.addr;
      BURST_WRAP:  next_addr = (r.addr & ~mask) | ((r.addr + inc) & mask);
      default:     next_addr = r.addr + inc;   // Reserved type treated as incrementing
    endcase
  endfunction

  // Queue of accepted groups; its fullness holds back the slave port
  aw_fifo #(
    .WIDTH ($bits(aw_req_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .clock     (clock),
    .reset_n   (reset_n),
    .flush     (in_rst),
    .in_valid  (q.hold_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (q.hold),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_raw)
  );

  // Next-state logic for the whole front end
  always_comb
  begin
    d = q;
    // Pin synchronisers; a level counts once stages two and three agree
    d.s1  = {lite_slave_clock, lite_master_clock, physical_link_clock, reset_n};
    d.s2  = q.s1;
    d.s3  = q.s2;
    agree = ~(q.s2 ^ q.s3);
    d.lvl = (q.s3 & agree) | (q.lvl & ~agree);
    rise  = agree & q.s3 & ~q.lvl;
    in_rst = ~q.lvl[PIN_RESET];   // R6
    // Link rises are seen three to four cycles late, so the link clock must stay below clock/4
    // Link side follows the slave-port clock or the sampled link clock
    link_step = COMMON_CLOCK_MODE ? 1'b1 : rise[PIN_PHY];   // R2 R3

    // Lightweight word taken on the rising edge of the selected port clock
    lite_edge = LITE_SLAVE_MODE ? rise[PIN_LITE_M] : rise[PIN_LITE_S];   // R8 R9
    d.lite_pipe  = {q.lite_pipe[1:0], {lite_in_valid, lite_in_data}};
    d.lite_valid = lite_edge & q.lite_pipe[2][LITE_WIDTH];
    if (lite_edge)
    begin
      d.lite_word = q.lite_pipe[2][LITE_WIDTH-1:0];
    end

    // Slave port runs on clock alone, whatever the link does
    fire = s_axi_awvalid & q.awready;   // R1 R16
    if (q.hold_valid & fifo_in_ready)
    begin
      d.hold_valid = 1'b0;
    end
    if (fire)
    begin
      d.hold_valid = 1'b1;
      d.hold.id    = ID_WIDTH_MAX'(s_axi_awid);   // R10
      d.hold.addr  = s_axi_awaddr;   // R11
      d.hold.len   = s_axi_awlen;   // R12
      d.hold.size  = s_axi_awsize;   // R13
      d.hold.burst = s_axi_awburst;   // R14
    end
    // Ready only while the holding stage is free; costs one idle cycle per group
    d.awready = ~d.hold_valid;

    // Beat engine, stalled by the link side
    adv = link_step & (~q.beat_valid | beat_ready);
    pop = adv & ~q.busy & fifo_out_valid & ~in_rst;
    if (pop)
    begin
      d.beat_valid = 1'b1;
      d.beat.id    = fifo_head.id;
      d.beat.addr  = fifo_head.addr;   // R11
      d.beat.size  = fifo_head.size;   // R13
      d.beat.last  = (fifo_head.len == 8'h00);   // R12
      d.busy       = (fifo_head.len != 8'h00);
      d.cur        = fifo_head;
      d.cur.addr   = next_addr(fifo_head);   // R14
      d.left       = fifo_head.len;
    end
    else if (adv & q.busy)
    begin
      d.beat_valid = 1'b1;
      d.beat.id    = q.cur.id;
      d.beat.addr  = q.cur.addr;
      d.beat.size  = q.cur.size;
      d.beat.last  = (q.left == 8'h01);   // R12
      d.busy       = (q.left != 8'h01);
      d.cur.addr   = next_addr(q.cur);   // R14
      d.left       = q.left - 8'h01;
    end
    else if (adv)
    begin
      d.beat_valid = 1'b0;
    end

    // Synchronous reset of the operating state; synchronisers keep running
    if (in_rst)
    begin
      d.awready    = 1'b0;
      d.hold_valid = 1'b0;
      d.busy       = 1'b0;
      d.beat_valid = 1'b0;
      d.lite_valid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q     <= '0;
      q.lvl <= PIN_LEVEL_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready   = q.awready;
  assign beat_valid      = q.beat_valid;
  assign beat            = q.beat;
  assign lite_word_valid = q.lite_valid;
  assign lite_word       = q.lite_word;

  // Checks of the capture, beat and clocking behaviour
  property p_capture;
    @(posedge clock) disable iff (!reset_n)
    fire && !in_rst |=> q.hold_valid && q.hold.addr == $past(s_axi_awaddr)
                        && q.hold.len == $past(s_axi_awlen);
  endproperty
  a_capture: assert property (p_capture) else $error("write address not captured");   // R16

  property p_ready_drop;
    @(posedge clock) disable iff (!reset_n)
    fire |=> !s_axi_awready;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready held after transfer");   // R1

  property p_first_beat;
    @(posedge clock) disable iff (!reset_n)
    pop |=> beat_valid && beat.addr == $past(fifo_head.addr) && beat.size == $past(fifo_head.size);
  endproperty
  a_first_beat: assert property (p_first_beat) else $error("first beat address wrong");   // R11

  property p_single_last;
    @(posedge clock) disable iff (!reset_n)
    pop && fifo_head.len == 8'h00 |=> beat.last;
  endproperty
  a_single_last: assert property (p_single_last) else $error("single beat not last");   // R12

  property p_incr_step;
    @(posedge clock) disable iff (!reset_n || in_rst)
    adv && q.busy && q.cur.burst == BURST_INCR
      |=> beat.addr + (32'h1 << beat.size) == q.cur.addr;
  endproperty
  a_incr_step: assert property (p_incr_step) else $error("incrementing step wrong");   // R14

  property p_fixed_step;
    @(posedge clock) disable iff (!reset_n || in_rst)
    adv && q.busy && q.cur.burst == BURST_FIXED |=> beat.addr == $past(beat.addr);
  endproperty
  a_fixed_step: assert property (p_fixed_step) else $error("fixed burst address moved");   // R14

  property p_common_go;
    @(posedge clock) disable iff (!reset_n || in_rst)
    COMMON_CLOCK_MODE && !q.beat_valid && !q.busy && fifo_out_valid |=> beat_valid;
  endproperty
  a_common_go: assert property (p_common_go) else $error("common clock beat stalled");   // R2

  property p_indep_hold;
    @(posedge clock) disable iff (!reset_n || in_rst)
    !COMMON_CLOCK_MODE && !rise[PIN_PHY] |=> $stable(beat_valid) && $stable(beat);
  endproperty
  a_indep_hold: assert property (p_indep_hold) else $error("beat moved off link edge");   // R3

  property p_reset_quiet;
    @(posedge clock) disable iff (!reset_n)
    in_rst |=> !s_axi_awready && !beat_valid && !lite_word_valid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");   // R6

  property p_lite_edge;
    @(posedge clock) disable iff (!reset_n)
    !lite_edge |=> !lite_word_valid;
  endproperty
  a_lite_edge: assert property (p_lite_edge) else $error("lite word off clock edge");   // R8 R9

  property p_beat_fields;
    @(posedge clock) disable iff (!reset_n || in_rst)
    adv && q.busy |=> beat.size == $past(q.cur.size) && beat.id == $past(q.cur.id);
  endproperty
  a_beat_fields: assert property (p_beat_fields) else $error("later beat size or tag changed");   // R13

  // Narrow tags are widened with zeros so upper tag bits never carry stale values
  property p_id_capture;
    @(posedge clock) disable iff (!reset_n)
    fire && !in_rst |=> q.hold.id == ID_WIDTH_MAX'($past(s_axi_awid));
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("write tag not captured");   // R10

  property p_lite_capture;
    @(posedge clock) disable iff (!reset_n || in_rst)
    lite_edge && q.lite_pipe[2][LITE_WIDTH] |=> lite_word_valid
      && lite_word == $past(q.lite_pipe[2][LITE_WIDTH-1:0]);
  endproperty
  a_lite_capture: assert property (p_lite_capture) else $error("lite word not captured");   // R8 R9

  c_fire: cover property (@(posedge clock) disable iff (!reset_n) fire);
  c_burst_end: cover property (@(posedge clock) disable iff (!reset_n)
    beat_valid && beat_ready && beat.last && q.cur.len != 8'h00);
  c_lite: cover property (@(posedge clock) disable iff (!reset_n) lite_word_valid);
  c_link_take: cover property (@(posedge clock) disable iff (!reset_n)
    !COMMON_CLOCK_MODE && beat_valid && beat_ready && rise[PIN_PHY]);

endmodule

`default_nettype wire

// >>> testbench/aw_master_model.sv
// Upstream write-address master model that drives the bridge slave port
`timescale 1ns/100ps
`default_nettype none

module aw_master_model
  import bridge_aw_pkg::*;
#(
  parameter int unsigned IDW = 4
) (
  // Clock
  input  wire logic           clock,
  // Write address channel
  output logic [IDW-1:0]      awid,
  output logic [31:0]         awaddr,
  output logic [7:0]          awlen,
  output logic [1:0]          awsize,
  output logic [1:0]          awburst,
  output logic                awvalid,
  input  wire logic           awready
);
  // Idle channel at time zero
  initial
  begin
    awvalid = 1'b0;
    {awid, awaddr, awlen, awsize, awburst} = '0;
  end

  // Offer one group for at most max_wait cycles; ok tells whether it was taken
  task automatic send(input aw_req_t r, input int max_wait, output bit ok);
    ok = 1'b0;
    @(negedge clock);
    awvalid = 1'b1;
    {awid, awaddr, awlen, awsize, awburst} = {r.id[IDW-1:0], r.addr, r.len, r.size, r.burst};
    // Fields stay put until ready is seen at a sampling edge
    for (int i = 0; i < max_wait && !ok; i++)
    begin
      #1;
      ok = (awready === 1'b1);
      @(negedge clock);
    end
    // Released fields show the inverse so a stale capture cannot pass
    awvalid = 1'b0;
    {awid, awaddr, awlen, awsize, awburst} = ~{awid, awaddr, awlen, awsize, awburst};
  endtask
endmodule
`default_nettype wire

// >>> testbench/bridge_master_clock_reset_aw_tb_top.sv
// Self-checking testbench for the write-address front end
`timescale 1ns/100ps
`default_nettype none

module bridge_master_clock_reset_aw_tb_top
  import bridge_aw_pkg::*;
;
  localparam int unsigned IDW = 4;
  localparam int unsigned FD  = 32;

  typedef struct packed { aw_req_t r; logic stall; logic [31:0] end_addr; } row_t;

  logic           clock, reset_n, physical_link_clock, lite_master_clock, lite_slave_clock;
  logic [IDW-1:0] awid;
  logic [31:0]    awaddr, lite_in_data, lite_word;
  logic [7:0]     awlen;
  logic [1:0]     awsize, awburst;
  logic           awvalid, awready, beat_valid, beat_ready, lite_in_valid, lite_word_valid;
  aw_beat_t       beat;
  int             n_fail, cmp_count, cycles, acc, pulses;
  bit             ok;
  aw_req_t        g;
  logic           ind_sel, ind_awready, ind_beat_valid;
  logic [31:0]    ind_lite_word, last_seen;
  aw_beat_t       ind_beat;
  int             gap;

  // Ordinary bursts with their last beat address: every burst type, sizes, wraps, longest length
  row_t rows [8] = '{
    '{'{6'h3, 32'h0000_0100, 8'h01, 2'h2, BURST_INCR}, 1'b0, 32'h0000_0104},
    '{'{6'hf, 32'h0000_0200, 8'h00, 2'h0, BURST_FIXED}, 1'b0, 32'h0000_0200},
    '{'{6'h5, 32'h0000_030c, 8'h03, 2'h2, BURST_FIXED}, 1'b1, 32'h0000_030c},
    '{'{6'h9, 32'h0000_1034, 8'h03, 2'h2, BURST_WRAP}, 1'b1, 32'h0000_1030},
    '{'{6'ha, 32'h0000_2ffe, 8'h07, 2'h1, BURST_WRAP}, 1'b0, 32'h0000_2ffc},
    '{'{6'h0, 32'hffff_ffd0, 8'h04, 2'h3, BURST_INCR}, 1'b1, 32'hffff_fff0},
    '{'{6'h1, 32'h0000_0400, 8'h02, 2'h1, 2'h3}, 1'b0, 32'h0000_0404},
    '{'{6'h2, 32'h0000_0500, 8'hff, 2'h2, BURST_INCR}, 1'b0, 32'h0000_08fc}};

  // Clocks; the slave-port clock runs before reset is released, the link clock first rises three cycles after it, lite clock pins stay low until driven
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Link clock toggles freely; common-clock mode must ignore it
  initial
  begin
    physical_link_clock = 1'b0;
    forever
    begin
      repeat (5) @(negedge clock);
      physical_link_clock = ~physical_link_clock;
    end
  end

  aw_master_model #(.IDW(IDW)) master (
    .clock(clock), .awid(awid), .awaddr(awaddr), .awlen(awlen), .awsize(awsize),
    .awburst(awburst), .awvalid(awvalid), .awready(ind_sel ? ind_awready : awready));

  bridge_aw_front #(
    .COMMON_CLOCK_MODE(1'b1), .LITE_SLAVE_MODE(1'b1), .id_width_parameter(IDW), .FIFO_DEPTH(FD)
  ) dut (
    .clock(clock), .reset_n(reset_n), .physical_link_clock(physical_link_clock),
    .lite_master_clock(lite_master_clock), .lite_slave_clock(lite_slave_clock),
    .s_axi_awid(awid), .s_axi_awaddr(awaddr), .s_axi_awlen(awlen), .s_axi_awsize(awsize),
    .s_axi_awburst(awburst), .s_axi_awvalid(awvalid & ~ind_sel), .s_axi_awready(awready),
    .beat_valid(beat_valid), .beat(beat), .beat_ready(beat_ready),
    .lite_in_valid(lite_in_valid), .lite_in_data(lite_in_data),
    .lite_word_valid(lite_word_valid), .lite_word(lite_word));

  // Second front end in independent-clock, lite-master mode; gets requests only while ind_sel
  bridge_aw_front #(
    .COMMON_CLOCK_MODE(1'b0), .LITE_SLAVE_MODE(1'b0), .id_width_parameter(IDW), .FIFO_DEPTH(FD)
  ) dut_ind (
    .clock(clock), .reset_n(reset_n), .physical_link_clock(physical_link_clock),
    .lite_master_clock(lite_master_clock), .lite_slave_clock(lite_slave_clock),
    .s_axi_awid(awid), .s_axi_awaddr(awaddr), .s_axi_awlen(awlen), .s_axi_awsize(awsize),
    .s_axi_awburst(awburst), .s_axi_awvalid(awvalid & ind_sel), .s_axi_awready(ind_awready),
    .beat_valid(ind_beat_valid), .beat(ind_beat), .beat_ready(beat_ready),
    .lite_in_valid(lite_in_valid), .lite_in_data(lite_in_data),
    .lite_word_valid(), .lite_word(ind_lite_word));

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Address of beat i worked out independently of the design
  function automatic logic [31:0] exp_addr(input aw_req_t r, input int i);
    logic [31:0] step, span, base;
    step = 32'h1 << r.size;
    span = ({24'h0, r.len} + 32'h1) << r.size;
    base = r.addr & ~(span - 32'h1);
    case (r.burst)
      BURST_FIXED: exp_addr = r.addr;
      BURST_WRAP:  exp_addr = base + ((r.addr - base + step * 32'(i)) % span);
      default:     exp_addr = r.addr + step * 32'(i);
    endcase
  endfunction

  // Take all beats of one group; stall drops ready every other cycle
  task automatic collect(input aw_req_t r, input bit stall);
    int got;
    got = 0;
    for (int c = 0; c < 1000 && got <= int'(r.len); c++)
    begin
      @(negedge clock);
      beat_ready = stall ? c[0] : 1'b1;
      #1;
      if (beat_valid === 1'b1 && beat_ready)
      begin
        check("beat_addr", beat.addr, exp_addr(r, got));
        check("beat_size", beat.size, r.size);
        check("beat_id", beat.id, r.id & 6'h0f);
        check("beat_last", beat.last, got == int'(r.len));
        last_seen = beat.addr;
        got++;
      end
    end
    check("beat_count", got, int'(r.len) + 1);
    @(negedge clock);
    beat_ready = 1'b0;
  endtask

  // One rise of a lite clock pin with data held around it
  task automatic lite_rise(input bit use_slave, input logic [31:0] data, input int exp_pulses);
    @(negedge clock);
    lite_in_data = data;
    lite_in_valid = 1'b1;
    repeat (4) @(negedge clock);
    if (use_slave) lite_slave_clock = 1'b1;
    else lite_master_clock = 1'b1;
    pulses = 0;
    repeat (10)
    begin
      @(negedge clock);
      #1;
      if (lite_word_valid === 1'b1) pulses++;
    end
    check("lite_pulses", pulses, exp_pulses);
    check("lite_word", lite_word, 32'h5a5a_0001);
    {lite_master_clock, lite_slave_clock, lite_in_valid} = 3'h0;
    repeat (6) @(negedge clock);
  endtask

  // Hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  // Main sequence
  initial
  begin
    {ind_sel, reset_n, beat_ready, lite_in_valid, lite_master_clock, lite_slave_clock} = 6'h0;
    lite_in_data = 32'h0;
    repeat (2) @(negedge clock);
    check("awready_in_reset", awready, 1'b0);
    check("beat_valid_in_reset", beat_valid, 1'b0);
    reset_n = 1'b1;
    repeat (8) @(negedge clock);
    check("awready_after_reset", awready, 1'b1);
    foreach (rows[k])
    begin
      master.send(rows[k].r, 20, ok);
      check("accepted", ok, 1'b1);
      collect(rows[k].r, rows[k].stall);
      check("row_end_addr", last_seen, rows[k].end_addr);
    end
    // Queue fills with the link side stalled, then drains in order
    acc = 0;
    for (int k = 0; k < 40; k++)
    begin
      g = '{6'(k), 32'h1000 + 32'(k) * 32'h10, 8'h00, 2'h2, BURST_INCR};
      master.send(g, 12, ok);
      acc += int'(ok);
    end
    check("awready_full", awready, 1'b0);
    check("fill_depth", acc >= FD, 1'b1);
    for (int k = 0; k < acc; k++)
      collect('{6'(k), 32'h1000 + 32'(k) * 32'h10, 8'h00, 2'h2, BURST_INCR}, k[0]);
    check("drained", beat_valid, 1'b0);
    // Only the selected lite clock captures a word; the second front end listens to the other
    lite_rise(1'b0, 32'h5a5a_0001, 1);
    check("ind_lite_idle", ind_lite_word, 32'h0000_0000);
    lite_rise(1'b1, 32'h0bad_0002, 0);
    check("ind_lite_word", ind_lite_word, 32'h0bad_0002);
    // Independent-clock front end moves its beats only on link clock rises, ten cycles apart
    ind_sel = 1'b1;
    beat_ready = 1'b1;
    master.send(rows[0].r, 20, ok);
    check("ind_accepted", ok, 1'b1);
    gap = 0;
    for (int c = 0; c < 60 && !(ind_beat_valid === 1'b1 && ind_beat.last === 1'b1); c++)
    begin
      @(negedge clock);
      #1;
      if (ind_beat_valid === 1'b1 && ind_beat.addr === 32'h0000_0100) gap++;
    end
    check("ind_beat_span", gap, 10);
    check("ind_last_addr", ind_beat.addr, 32'h0000_0104);
    repeat (12) @(negedge clock);
    check("ind_drained", ind_beat_valid, 1'b0);
    {ind_sel, beat_ready} = 2'h0;
    // Reset in mid-burst discards pending beats
    master.send(rows[3].r, 20, ok);
    repeat (6) @(negedge clock);
    check("beat_pending", beat_valid, 1'b1);
    reset_n = 1'b0;
    #1;
    check("beat_cleared", beat_valid, 1'b0);
    check("awready_cleared", awready, 1'b0);
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (8) @(negedge clock);
    check("no_stale_beat", beat_valid, 1'b0);
    check("awready_again", awready, 1'b1);
    master.send(rows[0].r, 20, ok);
    collect(rows[0].r, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
